// File: hw/smc_pkg.sv
// Package with constants and types of the standby mode controller.
package smc_pkg;

	localparam int          STBCTL_W         = 8;
	localparam int          STBCTL_SEL_BIT   = 7;
	localparam int          STBCTL_FLOAT_BIT = 6;
	localparam logic [7:0]  STBCTL_RESET     = 8'h1F;
	localparam logic [7:0]  STBCTL_FIXED_ONE = 8'h1F;
	localparam int          WDT_CKS_W       = 3;
	localparam int          WDT_TICKS       = 256;
	localparam int          WDT_CNT_W       = 9;
	localparam int          PRESC_W         = 14;
	localparam logic [31:0] PRESC_LOG2      = 32'hD_C_9_8_7_6_5_1;
	localparam logic        NMI_FALLING     = 1'b0;
	localparam logic        NMI_RISING      = 1'b1;
	localparam int          SYNC_STAGES     = 3;

	typedef enum logic [1:0] {
		SMC_RUN,
		SMC_SLEEP,
		SMC_STANDBY,
		SMC_SETTLE
	} smc_state_e;

	typedef struct packed {
		logic standby_select;
		logic port_float;
	} smc_stbctl_s;

	typedef struct packed {
		logic dma_unit;
		logic multi_channel_timer;
		logic serial_interface;
		logic wdt_control_hi;
		logic wdt_reset_status;
	} smc_unit_reset_s;

	typedef struct packed {
		logic cpu_run;
		logic sys_clk_en;
		logic periph_clk_en;
		logic wdt_clk_en;
		logic retain;
	} smc_clk_ctl_s;

endpackage

// File: hw/smc_settle_timer.sv
// Oscillator settling timer: prescaled count to overflow.
`timescale 1ns/1ns
`default_nettype none
module smc_settle_timer
	import smc_pkg::*;
#(
	parameter int          TICKS    = WDT_TICKS,
	parameter logic [31:0] LOG2_TAB = PRESC_LOG2
) (
	input  wire logic                 clk,
	input  wire logic                 rst,
	input  wire logic                 run,
	input  wire logic [WDT_CKS_W-1:0] cks,
	output logic                      overflow
);
	logic [PRESC_W-1:0]   presc_q;
	logic [WDT_CNT_W-1:0] cnt_q;
	logic [3:0]           shift;
	logic [PRESC_W-1:0]   presc_top;
	logic                 tick;

	assign shift     = LOG2_TAB[4*cks +: 4];
	assign presc_top = PRESC_W'((PRESC_W+1)'(1) << shift) - PRESC_W'(1);
	assign tick      = run && (presc_q == presc_top);
	assign overflow  = tick && (cnt_q == WDT_CNT_W'(TICKS - 1));

	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			presc_q <= '0;
		end else if (!run || tick) begin
			presc_q <= '0;
		end else begin
			presc_q <= presc_q + PRESC_W'(1);
		end
	end

	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			cnt_q <= '0;
		end else if (!run || overflow) begin
			cnt_q <= '0;
		end else if (tick) begin
			cnt_q <= cnt_q + WDT_CNT_W'(1);
		end
	end
endmodule // smc_settle_timer
`default_nettype wire

// File: hw/smc_standby_ctrl.sv
// Standby and sleep mode controller with standby control register.
// Function
// - Sleep with standby_select set enters standby.
// - Standby stops CPU, clock and peripherals.
// - CPU registers and RAM held in standby.
// - Ports hold or float per port_float.
// - Entry resets DMA and multi-channel timer.
// - Entry resets watchdog bits 7-5, reset status.
// - Entry resets all serial interface registers.
// - Controller, port and standby registers kept.
// - Only NMI or reset pin leaves standby.
// - NMI edge restarts oscillator, watchdog clock only.
// - Watchdog overflow clocks chip, raises NMI exception.
// - Reset low with NMI high: power-on reset.
// - Reset low with NMI low: manual reset.
// - Standby forces falling edge; rising ignored.
// - Falling NMI for manual reset wakes first.
// - Setting bits refused while watchdog runs.
// - port_float one floats ports, zero holds.
// - standby_select zero gives sleep mode instead.
`timescale 1ns/1ns
`default_nettype none
module smc_standby_ctrl
	import smc_pkg::*;
#(
	parameter int          WDT_TICKS_P     = WDT_TICKS,
	parameter logic [31:0] PRESC_LOG2_P    = PRESC_LOG2,
	parameter bit          FORCE_FALL_STB  = 1'b1
) (
	input  wire logic                          MCLK,
	input  wire logic                          RST,
	input  wire logic                          SLEEP_EXEC,
	input  wire logic                          STBCTL_WR,
	input  wire logic [smc_pkg::STBCTL_W-1:0]  STBCTL_WDATA,
	output logic      [smc_pkg::STBCTL_W-1:0]  STBCTL_RDATA,
	input  wire logic                          WDT_RUN,
	input  wire logic [smc_pkg::WDT_CKS_W-1:0] WDT_CLOCK_SELECT,
	input  wire logic                          NMI_EDGE_SELECT,
	input  wire logic                          IRQ_ACCEPT,
	input  wire logic                          DMA_ADDR_ERR,
	input  wire logic                          NMI_PIN,
	input  wire logic                          RESET_IN_PIN_N,
	output smc_pkg::smc_clk_ctl_s              CLK_CTL,
	output smc_pkg::smc_unit_reset_s           UNIT_RESET,
	output logic                               PORT_HOLD,
	output logic                               PORT_FLOAT,
	output logic                               STANDBY,
	output logic                               SLEEPING,
	output logic                               NMI_EXC_REQ,
	output logic                               SLEEP_WAKE,
	output logic                               POWER_ON_RESET,
	output logic                               MANUAL_RESET
);
	import smc_pkg::*;

	smc_state_e             state_q;
	smc_state_e             state_d;
	smc_stbctl_s            stbctl_q;
	logic [SYNC_STAGES-1:0] nmi_sync_q;
	logic [SYNC_STAGES-1:0] res_sync_q;
	logic                   nmi_lvl_q;
	logic                   res_low_q;
	logic                   nmi_rise;
	logic                   nmi_fall;
	logic                   edge_sel;
	logic                   nmi_hit;
	logic                   res_hit;
	logic                   enter_stby;
	logic                   overflow;

	// Pin synchronisers; a change counts when the last two stages agree.
	always_ff @(posedge MCLK or posedge RST) begin
		if (RST) begin
			nmi_sync_q <= '0;
			res_sync_q <= '1;
		end else begin
			nmi_sync_q <= {nmi_sync_q[SYNC_STAGES-2:0], NMI_PIN};
			res_sync_q <= {res_sync_q[SYNC_STAGES-2:0], RESET_IN_PIN_N};
		end
	end

	always_ff @(posedge MCLK or posedge RST) begin
		if (RST) begin
			nmi_lvl_q <= 1'b0;
			res_low_q <= 1'b0;
		end else begin
			if (nmi_sync_q[1] == nmi_sync_q[2]) begin
				nmi_lvl_q <= nmi_sync_q[2];
			end
			if (res_sync_q[1] == res_sync_q[2]) begin
				res_low_q <= !res_sync_q[2];
			end
		end
	end

	always_comb begin
		nmi_rise = 1'b0;
		nmi_fall = 1'b0;
		if (nmi_sync_q[1] == nmi_sync_q[2]) begin
			nmi_rise = nmi_sync_q[2] && !nmi_lvl_q;
			nmi_fall = !nmi_sync_q[2] && nmi_lvl_q;
		end
	end

	assign edge_sel = (FORCE_FALL_STB && (state_q == SMC_STANDBY)) ? NMI_FALLING
		: NMI_EDGE_SELECT;
	assign nmi_hit  = (edge_sel == NMI_RISING) ? nmi_rise : nmi_fall;
	assign res_hit  = res_low_q;
	assign enter_stby = (state_q == SMC_RUN) && SLEEP_EXEC && stbctl_q.standby_select;

	always_ff @(posedge MCLK or posedge RST) begin
		if (RST) begin
			stbctl_q <= smc_stbctl_s'(STBCTL_RESET[STBCTL_SEL_BIT -: 2]);
		end else if (STBCTL_WR) begin
			if (!WDT_RUN || !STBCTL_WDATA[STBCTL_SEL_BIT]) begin
				stbctl_q.standby_select <= STBCTL_WDATA[STBCTL_SEL_BIT];
			end
			if (!WDT_RUN || !STBCTL_WDATA[STBCTL_FLOAT_BIT]) begin
				stbctl_q.port_float <= STBCTL_WDATA[STBCTL_FLOAT_BIT];
			end
		end
	end

	assign STBCTL_RDATA = {stbctl_q.standby_select, stbctl_q.port_float, 1'b0,
		STBCTL_FIXED_ONE[4:0]};

	always_comb begin
		state_d = state_q;
		unique case (state_q)
			SMC_RUN: begin
				if (SLEEP_EXEC) begin
					state_d = stbctl_q.standby_select ? SMC_STANDBY : SMC_SLEEP;
				end
			end
			SMC_SLEEP: begin
				if (res_hit || IRQ_ACCEPT || DMA_ADDR_ERR || nmi_hit) begin
					state_d = SMC_RUN;
				end
			end
			SMC_STANDBY: begin
				if (res_hit) begin
					state_d = SMC_RUN;
				end else if (nmi_hit) begin
					state_d = SMC_SETTLE;
				end
			end
			SMC_SETTLE: begin
				if (res_hit || overflow) begin
					state_d = SMC_RUN;
				end
			end
		endcase
	end

	always_ff @(posedge MCLK or posedge RST) begin
		if (RST) begin
			state_q <= SMC_RUN;
		end else begin
			state_q <= state_d;
		end
	end

	smc_settle_timer #(
		.TICKS    (WDT_TICKS_P),
		.LOG2_TAB (PRESC_LOG2_P)
	) u_settle (
		.clk      (MCLK),
		.rst      (RST),
		.run      (state_q == SMC_SETTLE),
		.cks      (WDT_CLOCK_SELECT),
		.overflow (overflow)
	);

	always_ff @(posedge MCLK or posedge RST) begin
		if (RST) begin
			UNIT_RESET <= '0;
		end else begin
			UNIT_RESET <= {5{enter_stby}};
		end
	end

	always_ff @(posedge MCLK or posedge RST) begin
		if (RST) begin
			NMI_EXC_REQ <= 1'b0;
			SLEEP_WAKE  <= 1'b0;
		end else begin
			NMI_EXC_REQ <= (state_q == SMC_SETTLE) && overflow && !res_hit;
			SLEEP_WAKE  <= (state_q == SMC_SLEEP) && (state_d == SMC_RUN) && !res_hit;
		end
	end

	always_ff @(posedge MCLK or posedge RST) begin
		if (RST) begin
			POWER_ON_RESET <= 1'b0;
			MANUAL_RESET   <= 1'b0;
		end else begin
			POWER_ON_RESET <= res_hit && nmi_lvl_q;
			MANUAL_RESET   <= res_hit && !nmi_lvl_q;
		end
	end

	always_ff @(posedge MCLK or posedge RST) begin
		if (RST) begin
			CLK_CTL  <= '{cpu_run: 1'b1, sys_clk_en: 1'b1, periph_clk_en: 1'b1,
				wdt_clk_en: 1'b1, retain: 1'b0};
			STANDBY  <= 1'b0;
			SLEEPING <= 1'b0;
		end else begin
			CLK_CTL.cpu_run       <= state_d == SMC_RUN;
			CLK_CTL.sys_clk_en    <= (state_d == SMC_RUN) || (state_d == SMC_SLEEP);
			CLK_CTL.periph_clk_en <= (state_d == SMC_RUN) || (state_d == SMC_SLEEP);
			CLK_CTL.wdt_clk_en    <= state_d != SMC_STANDBY;
			CLK_CTL.retain        <= state_d != SMC_RUN;
			STANDBY               <= (state_d == SMC_STANDBY) || (state_d == SMC_SETTLE);
			SLEEPING              <= state_d == SMC_SLEEP;
		end
	end

	always_ff @(posedge MCLK or posedge RST) begin
		if (RST) begin
			PORT_HOLD  <= 1'b0;
			PORT_FLOAT <= 1'b0;
		end else begin
			PORT_HOLD  <= ((state_d == SMC_STANDBY) || (state_d == SMC_SETTLE))
				&& !stbctl_q.port_float;
			PORT_FLOAT <= ((state_d == SMC_STANDBY) || (state_d == SMC_SETTLE))
				&& stbctl_q.port_float;
		end
	end
endmodule // smc_standby_ctrl
`default_nettype wire

// File: bench/smc_monitor.sv
// Port checker of the standby mode controller.
`timescale 1ns/1ns
`default_nettype none
module smc_monitor
	import smc_pkg::*;
(
	input	wire logic			MCLK,
	input	wire logic			RST,
	input	wire logic			SLEEP_EXEC,
	input	wire logic			STBCTL_WR,
	input	wire logic [7:0]		STBCTL_WDATA,
	input	wire logic [7:0]		STBCTL_RDATA,
	input	wire logic			WDT_RUN,
	input	wire logic			NMI_PIN,
	input	wire logic			RESET_IN_PIN_N,
	input	wire smc_pkg::smc_clk_ctl_s	CLK_CTL,
	input	wire smc_pkg::smc_unit_reset_s	UNIT_RESET,
	input	wire logic			PORT_HOLD,
	input	wire logic			PORT_FLOAT,
	input	wire logic			STANDBY,
	input	wire logic			SLEEPING,
	input	wire logic			NMI_EXC_REQ,
	input	wire logic			POWER_ON_RESET,
	input	wire logic			MANUAL_RESET
);
	default clocking @(posedge MCLK); endclocking
	default disable iff (RST);
	logic	in_run;
	assign in_run = !STANDBY && !SLEEPING;
	stby_entry_a: assert property (
		SLEEP_EXEC && in_run && STBCTL_RDATA[7] |=> STANDBY && UNIT_RESET == 5'h1F && CLK_CTL == 5'h01)
		else $error("standby entry wrong");
	unit_pulse_a: assert property (UNIT_RESET != 5'h00 |=> UNIT_RESET == 5'h00)
		else $error("unit reset not one cycle");
	sleep_entry_a: assert property (
		SLEEP_EXEC && in_run && !STBCTL_RDATA[7] |=> SLEEPING && !STANDBY && CLK_CTL.sys_clk_en)
		else $error("sleep entry wrong");
	port_mode_a: assert property (
		STANDBY |-> PORT_FLOAT == STBCTL_RDATA[6] && PORT_HOLD == !STBCTL_RDATA[6])
		else $error("port state wrong");
	reg_write_a: assert property (STBCTL_WR |=> STBCTL_RDATA == {
		($past(WDT_RUN) ? $past(STBCTL_RDATA[7:6]) & $past(STBCTL_WDATA[7:6])
		: $past(STBCTL_WDATA[7:6])), 6'h1F}) else $error("register write wrong");
	exc_exit_a: assert property (
		NMI_EXC_REQ |-> !STANDBY && CLK_CTL.cpu_run && $past(STANDBY) ##1 !NMI_EXC_REQ)
		else $error("exception exit wrong");
	settle_run_a: assert property (
		$rose(CLK_CTL.wdt_clk_en) && STANDBY |-> !CLK_CTL.cpu_run ##[1:8] NMI_EXC_REQ)
		else $error("settling wrong");
	stby_halt_a: assert property (
		STANDBY |-> CLK_CTL.retain && !CLK_CTL.sys_clk_en && !CLK_CTL.periph_clk_en)
		else $error("clocks run in standby");
	por_exit_a: assert property (
		$fell(RESET_IN_PIN_N) && NMI_PIN && $past(NMI_PIN, 4) |-> ##[2:6] POWER_ON_RESET && !STANDBY)
		else $error("power-on reset missing");
	man_exit_a: assert property (
		$fell(RESET_IN_PIN_N) && !NMI_PIN && !$past(NMI_PIN, 4) |-> ##[2:6] MANUAL_RESET && !STANDBY)
		else $error("manual reset missing");
	cover property (SLEEP_EXEC && STBCTL_RDATA[7]);
	cover property (NMI_EXC_REQ);
	cover property (MANUAL_RESET);
endmodule // smc_monitor
`default_nettype wire

// File: bench/smc_pin_drv.sv
// Model of the external NMI and reset pin drivers.
`timescale 1ns/1ns
`default_nettype none
module smc_pin_drv (
	input	wire logic	nmi_lvl,
	input	wire logic	rst_lvl_n,
	output	logic		nmi_pin,
	output	logic		reset_pin_n
);
	assign #7 nmi_pin = nmi_lvl;
	assign #7 reset_pin_n = rst_lvl_n;
endmodule // smc_pin_drv
`default_nettype wire

// File: bench/smc_standby_ctrl_test.sv
// Self-checking bench of the standby mode controller.
`timescale 1ns/1ns
`default_nettype none
`define CHK(a, e) begin num_checks++; if ((a) !== (e)) begin fail_count++; \
	$display("BAD %0t got %h want %h", $time, a, e); end end
module smc_standby_ctrl_test;
	import smc_pkg::*;
	logic			MCLK = 0, RST = 1, SLEEP_EXEC = 0, STBCTL_WR = 0, WDT_RUN = 0;
	logic [2:0]		WDT_CLOCK_SELECT = 3'h0;
	logic			NMI_EDGE_SELECT = 0, IRQ_ACCEPT = 0, DMA_ADDR_ERR = 0;
	logic			nmi_lvl = 1, rst_lvl_n = 1, NMI_PIN, RESET_IN_PIN_N;
	logic [7:0]		STBCTL_WDATA = 8'h00, STBCTL_RDATA;
	smc_clk_ctl_s		CLK_CTL;
	smc_unit_reset_s	UNIT_RESET;
	logic			PORT_HOLD, PORT_FLOAT, STANDBY, SLEEPING, NMI_EXC_REQ;
	logic			SLEEP_WAKE, POWER_ON_RESET, MANUAL_RESET;
	int			fail_count = 0, num_checks = 0, cyc = 0, i;
	smc_standby_ctrl #(.WDT_TICKS_P(2), .PRESC_LOG2_P(32'h0000_0010), .FORCE_FALL_STB(1'b1)) uut (
		.MCLK, .RST, .SLEEP_EXEC, .STBCTL_WR, .STBCTL_WDATA, .STBCTL_RDATA, .WDT_RUN,
		.WDT_CLOCK_SELECT, .NMI_EDGE_SELECT, .IRQ_ACCEPT, .DMA_ADDR_ERR, .NMI_PIN,
		.RESET_IN_PIN_N, .CLK_CTL, .UNIT_RESET, .PORT_HOLD, .PORT_FLOAT, .STANDBY, .SLEEPING,
		.NMI_EXC_REQ, .SLEEP_WAKE, .POWER_ON_RESET, .MANUAL_RESET);
	smc_pin_drv drv (.nmi_lvl, .rst_lvl_n, .nmi_pin(NMI_PIN), .reset_pin_n(RESET_IN_PIN_N));
	always #50 MCLK = ~MCLK;
	always @(posedge MCLK) begin
		cyc++;
		if (cyc == 2000) begin
			fail_count++;
			print_verdict();
		end
	end
	task automatic print_verdict();
		if (fail_count == 0 && num_checks > 0)
			$display("NO MISMATCHES");
		else
			$display("MISMATCHES SEEN");
		$finish;
	endtask
	task automatic step(int n = 1);
		repeat (n) @(posedge MCLK);
		#1;
	endtask
	task automatic wr(logic [7:0] d, logic run);
		STBCTL_WDATA = d;
		WDT_RUN = run;
		STBCTL_WR = 1;
		step();
		STBCTL_WR = 0;
	endtask
	task automatic slp();
		SLEEP_EXEC = 1;
		step();
		SLEEP_EXEC = 0;
	endtask
	task automatic wt(ref logic s);
		i = 0;
		while (s !== 1'b1 && i < 40) begin
			step();
			i++;
		end
	endtask
	initial begin
		step(3);
		RST = 0;
		`CHK(STBCTL_RDATA, 8'h1F)
		`CHK(CLK_CTL, 5'h1E)
		wr(8'hC0, 1); `CHK(STBCTL_RDATA, 8'h1F)
		wr(8'hC0, 0); `CHK(STBCTL_RDATA, 8'hDF)
		wr(8'h40, 1); `CHK(STBCTL_RDATA, 8'h5F)
		wr(8'h00, 0);
		for (int k = 0; k < 2; k++) begin
			slp(); `CHK({SLEEPING, STANDBY, CLK_CTL.sys_clk_en}, 3'h5)
			IRQ_ACCEPT = (k == 0);
			DMA_ADDR_ERR = (k == 1);
			step();
			IRQ_ACCEPT = 0;
			DMA_ADDR_ERR = 0;
			wt(SLEEP_WAKE); `CHK(SLEEP_WAKE, 1'b1)
			step(2);
		end
		wr(8'h80, 0);
		slp(); `CHK({STANDBY, PORT_HOLD, PORT_FLOAT, UNIT_RESET}, 8'hDF)
		`CHK(CLK_CTL, 5'h01)
		step(); `CHK(UNIT_RESET, 5'h00)
		IRQ_ACCEPT = 1;
		DMA_ADDR_ERR = 1;
		step(6);
		IRQ_ACCEPT = 0;
		DMA_ADDR_ERR = 0;
		`CHK({STANDBY, STBCTL_RDATA}, 9'h19F)
		nmi_lvl = 0;
		wt(NMI_EXC_REQ); `CHK({NMI_EXC_REQ, STANDBY, CLK_CTL[4:2]}, 5'h17)
		NMI_EDGE_SELECT = 1;
		WDT_CLOCK_SELECT = 3'h1;
		wr(8'hC0, 0);
		slp(); `CHK({STANDBY, PORT_HOLD, PORT_FLOAT}, 3'h5)
		nmi_lvl = 1;
		step(12); `CHK(STANDBY, 1'b1)
		nmi_lvl = 0;
		wt(NMI_EXC_REQ); `CHK(NMI_EXC_REQ, 1'b1)
		NMI_EDGE_SELECT = 0;
		for (int k = 0; k < 2; k++) begin
			nmi_lvl = (k == 0);
			step(8);
			wr(8'h80, 0);
			slp();
			rst_lvl_n = 0;
			step(8); `CHK({STANDBY, POWER_ON_RESET, MANUAL_RESET}, k ? 3'h1 : 3'h2)
			rst_lvl_n = 1;
			step(8); `CHK({POWER_ON_RESET, MANUAL_RESET, STBCTL_RDATA}, 10'h09F)
		end
		print_verdict();
	end
endmodule // smc_standby_ctrl_test
bind smc_standby_ctrl smc_monitor mon (.MCLK, .RST, .SLEEP_EXEC, .STBCTL_WR, .STBCTL_WDATA,
	.STBCTL_RDATA, .WDT_RUN, .NMI_PIN, .RESET_IN_PIN_N, .CLK_CTL, .UNIT_RESET, .PORT_HOLD,
	.PORT_FLOAT, .STANDBY, .SLEEPING, .NMI_EXC_REQ, .POWER_ON_RESET, .MANUAL_RESET);
`default_nettype wire
